// File: rbi_backplane_model.sv
// Behavioural system backplane device: backplane clock, frame input and data sink.
`timescale 1ns/1ps
module rbi_backplane_model #(
  parameter int HALF_NS = 43
) (
  output logic bp_clk,
  output logic bp_fs,
  input  logic rx_data,
  input  logic rx_data_oe
);
  int   bit_n = 0;
  logic seen = 1'b0;
  initial bp_clk = 1'b0;
  initial bp_fs = 1'b0;
  // A system clock runs free, unrelated in phase to the block clock.
  always #(HALF_NS) bp_clk = ~bp_clk;
  // Frame input moves on the falling edge, so a rising-edge sampler sees it settled.
  always @(negedge bp_clk) begin
    bp_fs <= (bit_n == 0);
    bit_n <= (bit_n == 192) ? 0 : bit_n + 1;
  end
  // A released data line is not trusted: the inverse of the last level is seen.
  always @(posedge bp_clk) begin
    seen <= rx_data_oe ? rx_data : ~seen;
  end
endmodule

// File: rbi_checker_assertions.sv
// Concurrent checks on the ports of the receive backplane block.
`timescale 1ns/1ps
`include "rbi_defines.vh"
module rbi_checker (
  input logic        clk,
  input logic        rst_n,
  input logic [7:0]  avs_address,
  input logic        avs_read,
  input logic        avs_write,
  input logic [31:0] avs_writedata,
  input logic [3:0]  avs_byteenable,
  input logic [31:0] avs_readdata,
  input logic        avs_waitrequest,
  input logic        rx_backplane_data_oe,
  input logic [1:0]  mux_rx_data_oe,
  input logic [1:0]  mux_rx_signaling_oe,
  input logic        irq,
  input logic        frame_search_disable,
  input logic        sig_buffer_freeze,
  input logic        force_out_of_frame
);
  // ----------------------------------------------------------------
  // Shadow registers
  // ----------------------------------------------------------------
  // Shadows follow the bus, so no internal state of the block is needed.
  logic [7:0] unf_sh, opt_sh, par_sh, cfg_sh;
  logic       mux_on;
  logic [1:0] bus_exp;
  assign mux_on = (opt_sh[7:6] == `RBI_MODE_SIG) && (opt_sh[4:3] == 2'h1);
  assign bus_exp = (cfg_sh[5:4] == `RBI_TRI_NORM && cfg_sh[6]) ? (cfg_sh[7] ? 2'h2 : 2'h1) : 2'h0;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      unf_sh <= `RBI_LINE_RST;
      opt_sh <= `RBI_OPT_RST;
      par_sh <= `RBI_PAR_RST;
      cfg_sh <= `RBI_CFG_RST;
    end else if (avs_write && avs_byteenable[0]) begin
      if (avs_address[7:2] == `RBI_IDX_LINE) unf_sh <= avs_writedata[7:0] & `RBI_LINE_WMASK;
      if (avs_address[7:2] == `RBI_IDX_OPT) opt_sh <= avs_writedata[7:0];
      if (avs_address[7:2] == `RBI_IDX_PAR) par_sh <= avs_writedata[7:0] & `RBI_PAR_WMASK;
      if (avs_address[7:2] == `RBI_IDX_CFG) cfg_sh <= avs_writedata[7:0];
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_write_nowait: assert property (avs_write |-> !avs_waitrequest)
    else $error("write stalled");
  chk_read_wait: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read answer not one cycle late");
  chk_opt_readback: assert property (
    (avs_read && !avs_waitrequest && avs_address[7:2] == `RBI_IDX_OPT)
      |-> avs_readdata == {24'h0, opt_sh}) else $error("options readback wrong");
  chk_cfg_readback: assert property (
    (avs_read && !avs_waitrequest && avs_address[7:2] == `RBI_IDX_CFG)
      |-> avs_readdata == {24'h0, cfg_sh}) else $error("interface readback wrong");
  chk_tri_float: assert property (
    cfg_sh[5:4] == 2'h0 |-> !rx_backplane_data_oe && mux_rx_data_oe == 2'h0)
    else $error("data driven while floating");
  chk_mux_data_oe: assert property (
    mux_on |-> (mux_rx_data_oe & ~bus_exp) == 2'h0) else $error("mux data off its bus");
  chk_mux_sig_oe: assert property (
    mux_on |-> (mux_rx_signaling_oe & ~bus_exp) == 2'h0) else $error("mux signaling off its bus");
  chk_unf_follow: assert property (
    $stable(unf_sh[6]) |-> {frame_search_disable, sig_buffer_freeze, force_out_of_frame}
      == {3{unf_sh[6]}}) else $error("unframed outputs wrong");
  chk_irq_cause: assert property (
    $rose(irq) |-> par_sh[6] && opt_sh[7:6] != `RBI_MODE_FRAC) else $error("irq not enabled");
  chk_irq_off: assert property (!par_sh[6] [*3] |-> !irq)
    else $error("irq while disabled");
  cover property (mux_on && bus_exp == 2'h2);
  cover property ($rose(irq));
  cover property ($rose(frame_search_disable));
endmodule

// File: rbi_defines.vh
// Register indexes, field positions, reset values and frame counts of the receive backplane block.
`ifndef RBI_DEFINES_VH
`define RBI_DEFINES_VH

// ----------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define RBI_IDX_LINE   6'h00
`define RBI_IDX_OPT    6'h01
`define RBI_IDX_PAR    6'h02
`define RBI_IDX_CFG    6'h03

// ----------------------------------------------------------------
// Reset values and write masks
// ----------------------------------------------------------------
`define RBI_LINE_RST   8'h00
`define RBI_OPT_RST    8'hc0
`define RBI_PAR_RST    8'h00
`define RBI_CFG_RST    8'h00
`define RBI_LINE_WMASK 8'h40
`define RBI_PAR_WMASK  8'hcb

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RBI_UNF        6
`define RBI_MODE_HI    7
`define RBI_MODE_LO    6
`define RBI_REFSEL     5
`define RBI_RATE2M     4
`define RBI_RATE8M     3
`define RBI_FSSF       2
`define RBI_FSALT      1
`define RBI_TKC        0
`define RBI_TX_PARITY_TYPE      7
`define RBI_TX_PARITY_IRQ_ENABLE     6
`define RBI_TX_DATA_PARITY_ERROR_FLAG       5
`define RBI_TX_SIG_PARITY_ERROR_FLAG     4
`define RBI_EXT        3
`define RBI_RX_PARITY_TYPE      1
`define RBI_RX_PARITY_ENABLE     0
`define RBI_MUX_BUS_SELECT       7
`define RBI_MUX_BUS_CONNECT       6
`define RBI_TRI_HI     5
`define RBI_TRI_LO     4
`define RBI_RCKRISE    3
`define RBI_LCKFALL    2
`define RBI_FSFALL     1
`define RBI_BCKRISE    0

// ----------------------------------------------------------------
// Mode codes and frame counts
// ----------------------------------------------------------------
`define RBI_MODE_FRAC  2'h0
`define RBI_MODE_FULL  2'h1
`define RBI_MODE_REF   2'h2
`define RBI_MODE_SIG   2'h3
`define RBI_TRI_NORM   2'h1
`define RBI_FBIT_LAST  8'hc0
`define RBI_REF_HALF   8'h61
`define RBI_E1_LAST    10'h0ff
`define RBI_MUX_LAST   10'h3ff
`define RBI_SF_LAST    5'h0b
`define RBI_ESF_LAST   5'h17

`endif

// File: rbi_rx_backplane.v
// Receive backplane interface of one T1 framer channel with its Avalon-MM registers.
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`include "rbi_defines.vh"

module rbi_rx_backplane #(
  parameter [1:0] MUX_SLOT  = 2'h0,
  parameter       MUX_FIRST = 1'b1
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire [7:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output wire [31:0] avs_readdata,
  output wire        avs_waitrequest,
  input  wire        line_rx_clock,
  input  wire        line_rx_data,
  input  wire        line_fbit,
  input  wire        line_sf_first,
  input  wire        esf_format,
  output wire [4:0]  rx_channel_index,
  input  wire        channel_select_a,
  input  wire        slot_data_subst,
  input  wire        slot_sig_subst,
  input  wire        payload_control_enable,
  input  wire [7:0]  data_cond_byte,
  input  wire [3:0]  sig_cond_nibble,
  input  wire [3:0]  rx_sig_abcd,
  input  wire        backplane_rx_clock,
  input  wire        backplane_rx_frame_input,
  output wire        rx_backplane_data,
  output wire        rx_backplane_data_oe,
  output wire        rx_output_clock,
  output wire        rx_output_clock_oe,
  output wire        rx_frame_pulse,
  output wire [1:0]  mux_rx_data,
  output wire [1:0]  mux_rx_data_oe,
  output wire [1:0]  mux_rx_signaling,
  output wire [1:0]  mux_rx_signaling_oe,
  output wire [1:0]  mux_rx_frame_pulse,
  output wire [1:0]  mux_rx_frame_pulse_oe,
  input  wire        tx_bit_valid,
  input  wire        tx_fbit,
  input  wire        tx_sf_first,
  input  wire        tx_backplane_data,
  input  wire        tx_backplane_signaling,
  output wire        irq,
  output wire        frame_search_disable,
  output wire        sig_buffer_freeze,
  output wire        force_out_of_frame
);

  // ----------------------------------------------------------------
  // Registers and decoded fields
  // ----------------------------------------------------------------
  reg  [7:0]  line_reg;
  reg  [7:0]  opt_reg;
  reg  [7:0]  par_reg;
  reg  [7:0]  cfg_reg;
  reg         tsd_flag_reg;
  reg         tss_flag_reg;
  reg         rd_ack_reg;
  reg  [7:0]  rdata_reg;
  reg         irq_reg;
  wire [1:0]  mode    = opt_reg[`RBI_MODE_HI:`RBI_MODE_LO];
  wire [1:0]  tri_sel = cfg_reg[`RBI_TRI_HI:`RBI_TRI_LO];
  wire        frac    = (mode == `RBI_MODE_FRAC);
  wire        slave   = mode[1];
  wire        mux_on  = opt_reg[`RBI_RATE8M] & ~opt_reg[`RBI_RATE2M];
  wire        drive   = (tri_sel == `RBI_TRI_NORM);
  wire        ext     = par_reg[`RBI_EXT];
  wire [5:0]  idx     = avs_address[7:2];
  wire        wr_ok   = avs_write & avs_byteenable[0];
  wire        rd_take = avs_read & rd_ack_reg;
  reg  [7:0]  rd_mux;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg  [2:0]  lck_s;
  reg  [1:0]  ldat_s;
  reg  [2:0]  bck_s;
  reg  [1:0]  bfs_s;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lck_s  <= 3'h0;
      ldat_s <= 2'h0;
      bck_s  <= 3'h0;
      bfs_s  <= 2'h0;
    end else begin
      lck_s  <= {lck_s[1:0], line_rx_clock};
      ldat_s <= {ldat_s[0], line_rx_data};
      bck_s  <= {bck_s[1:0], backplane_rx_clock};
      bfs_s  <= {bfs_s[0], backplane_rx_frame_input};
    end
  end

  wire l_rise = lck_s[1] & ~lck_s[2];
  wire l_fall = ~lck_s[1] & lck_s[2];
  wire b_rise = bck_s[1] & ~bck_s[2];
  wire b_fall = ~bck_s[1] & bck_s[2];
  wire l_samp = cfg_reg[`RBI_LCKFALL] ? l_fall : l_rise;
  wire b_upd  = cfg_reg[`RBI_BCKRISE] ? b_rise : b_fall;
  wire b_fs   = cfg_reg[`RBI_FSFALL] ? b_fall : b_rise;

  // ----------------------------------------------------------------
  // Line side: bit position, frame count and per-bit processing
  // ----------------------------------------------------------------
  reg  [7:0]  lbit_reg;
  reg  [4:0]  lframe_reg;
  reg         pend_reg;
  reg         dacc_reg;
  reg         sacc_reg;
  reg         dmem [0:192];
  reg         smem [0:192];
  reg         fmem [0:192];
  reg         mst_d_reg;
  reg         mst_s_reg;
  reg         mst_fp_reg;
  reg         mst_sel_reg;
  reg         proc_ok_reg;

  wire [7:0]  lpos   = lbit_reg - 8'h01;
  wire [2:0]  bpos   = lpos[2:0];
  wire        is_f   = (lbit_reg == 8'h00);
  wire        sf_st  = is_f & (lframe_reg == 5'h00);
  wire [4:0]  sf_end = esf_format ? `RBI_ESF_LAST : `RBI_SF_LAST;
  wire        all_tc = opt_reg[`RBI_TKC] & payload_control_enable;
  wire        d_sub  = all_tc | (~opt_reg[`RBI_TKC] & slot_data_subst);
  wire        s_sub  = all_tc | (~opt_reg[`RBI_TKC] & slot_sig_subst);
  wire [3:0]  s_src  = s_sub ? sig_cond_nibble : rx_sig_abcd;
  wire        par_on = par_reg[`RBI_RX_PARITY_ENABLE] & ~frac;
  wire        d_pay  = d_sub ? data_cond_byte[3'h7 - bpos] : pend_reg;
  wire        s_pay  = bpos[2] ? s_src[~bpos[1:0]] : 1'b0;
  reg         d_out;
  reg         s_out;
  reg         fp_now;

  assign rx_channel_index = lpos[7:3];

  always @* begin
    d_out = is_f ? pend_reg : d_pay;
    s_out = is_f ? pend_reg : s_pay;
    if (sf_st && par_on) begin
      d_out = dacc_reg ^ par_reg[`RBI_RX_PARITY_TYPE];
      s_out = sacc_reg ^ par_reg[`RBI_RX_PARITY_TYPE];
    end
    if (opt_reg[`RBI_FSSF] && !opt_reg[`RBI_FSALT]) begin
      fp_now = is_f & (lframe_reg == 5'h00);
    end else if (!opt_reg[`RBI_FSSF] && opt_reg[`RBI_FSALT]) begin
      fp_now = is_f & lframe_reg[0];
    end else if (!opt_reg[`RBI_FSSF]) begin
      fp_now = is_f;
    end else begin
      fp_now = 1'b0;
    end
  end

  always @(posedge clk) begin
    if (l_samp && proc_ok_reg) begin
      dmem[lbit_reg] <= d_out;
      smem[lbit_reg] <= s_out;
      fmem[lbit_reg] <= fp_now;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lbit_reg    <= 8'h00;
      lframe_reg  <= 5'h00;
      pend_reg    <= 1'b0;
      dacc_reg    <= 1'b0;
      sacc_reg    <= 1'b0;
      mst_d_reg   <= 1'b0;
      mst_s_reg   <= 1'b0;
      mst_fp_reg  <= 1'b0;
      mst_sel_reg <= 1'b0;
      proc_ok_reg <= 1'b0;
    end else if (l_samp) begin
      pend_reg    <= ldat_s[1];
      proc_ok_reg <= 1'b1;
      if (line_fbit) begin
        lbit_reg   <= 8'h00;
        lframe_reg <= (line_sf_first || lframe_reg == sf_end) ? 5'h00 : lframe_reg + 5'h01;
      end else if (lbit_reg == `RBI_FBIT_LAST) begin
        lbit_reg <= 8'h00;
      end else begin
        lbit_reg <= lbit_reg + 8'h01;
      end
      if (proc_ok_reg) begin
        mst_d_reg   <= d_out;
        mst_s_reg   <= s_out;
        mst_fp_reg  <= fp_now | (frac & mst_fp_reg & ~mst_sel_reg);
        mst_sel_reg <= ~frac | (~is_f & channel_select_a);
        if (sf_st) begin
          dacc_reg <= ext & d_out;
          sacc_reg <= ext & s_out;
        end else if (!is_f || ext) begin
          dacc_reg <= dacc_reg ^ d_out;
          sacc_reg <= sacc_reg ^ s_out;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Backplane side: slave read-out of the stored frame
  // ----------------------------------------------------------------
  reg  [9:0]  ocnt_reg;
  reg         fs_seen_reg;
  wire [9:0]  o_last = mux_on ? `RBI_MUX_LAST :
                       opt_reg[`RBI_RATE2M] ? `RBI_E1_LAST : {2'h0, `RBI_FBIT_LAST};
  wire [7:0]  o_idx  = mux_on ? ocnt_reg[9:2] : ocnt_reg[7:0];
  wire        o_mine = ~mux_on | (ocnt_reg[1:0] == MUX_SLOT);
  wire        o_val  = (o_idx <= `RBI_FBIT_LAST);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ocnt_reg    <= 10'h000;
      fs_seen_reg <= 1'b0;
    end else begin
      if (b_fs && bfs_s[1]) begin
        fs_seen_reg <= 1'b1;
      end else if (b_upd) begin
        fs_seen_reg <= 1'b0;
      end
      if (b_upd) begin
        if (fs_seen_reg || ocnt_reg == o_last) begin
          ocnt_reg <= 10'h000;
        end else begin
          ocnt_reg <= ocnt_reg + 10'h001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------
  reg         rck_reg;
  reg         rd_reg;
  reg         rs_reg;
  reg         rfp_reg;
  reg         mine_reg;
  reg         ref_reg;
  reg         pin_reg;
  wire        rck_next = lck_s[2] & (mode[0] | mst_sel_reg);
  wire        rck_edge = cfg_reg[`RBI_RCKRISE] ? (rck_next & ~rck_reg) : (~rck_next & rck_reg);
  reg         pin_next;

  always @* begin
    case (mode)
      `RBI_MODE_REF: pin_next = opt_reg[`RBI_REFSEL] ? lck_s[2] : ref_reg;
      `RBI_MODE_SIG: pin_next = rs_reg;
      default:       pin_next = rck_reg;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rck_reg  <= 1'b0;
      rd_reg   <= 1'b1;
      rs_reg   <= 1'b1;
      rfp_reg  <= 1'b0;
      mine_reg <= 1'b0;
      ref_reg  <= 1'b0;
      pin_reg  <= 1'b0;
    end else begin
      rck_reg <= rck_next;
      ref_reg <= (lbit_reg < `RBI_REF_HALF);
      pin_reg <= pin_next;
      if (!slave && rck_edge) begin
        rd_reg   <= mst_d_reg;
        rfp_reg  <= mst_fp_reg;
        rs_reg   <= mst_s_reg;
        mine_reg <= 1'b0;
      end else if (slave && b_upd) begin
        rd_reg   <= o_val ? dmem[o_idx] : 1'b1;
        rs_reg   <= o_val ? smem[o_idx] : 1'b1;
        rfp_reg  <= mux_on ? (o_idx == 8'h00) : (o_val & fmem[o_idx]);
        mine_reg <= mux_on & o_mine;
      end
    end
  end

  wire mux_act = mux_on & cfg_reg[`RBI_MUX_BUS_CONNECT] & drive & mine_reg;
  wire [1:0] bus_hot = cfg_reg[`RBI_MUX_BUS_SELECT] ? 2'h2 : 2'h1;
  wire [1:0] bus_oe  = mux_act ? bus_hot : 2'h0;

  assign rx_backplane_data     = rd_reg;
  assign rx_backplane_data_oe  = drive & ~mux_on;
  assign rx_output_clock       = pin_reg;
  assign rx_output_clock_oe    = (mode == `RBI_MODE_SIG) ? (drive & ~mux_on) : 1'b1;
  assign rx_frame_pulse        = rfp_reg;
  assign mux_rx_data           = {rd_reg, rd_reg};
  assign mux_rx_data_oe        = bus_oe;
  assign mux_rx_signaling      = {rs_reg, rs_reg};
  assign mux_rx_signaling_oe   = bus_oe;
  assign mux_rx_frame_pulse    = {rfp_reg, rfp_reg};
  assign mux_rx_frame_pulse_oe = MUX_FIRST ? bus_oe : 2'h0;

  // ----------------------------------------------------------------
  // Transmit F-bit parity check
  // ----------------------------------------------------------------
  reg         tdacc_reg;
  reg         tsacc_reg;
  wire        t_chk  = tx_bit_valid & tx_fbit & tx_sf_first;
  wire        t_exp_d = tdacc_reg ^ par_reg[`RBI_TX_PARITY_TYPE];
  wire        t_exp_s = tsacc_reg ^ par_reg[`RBI_TX_PARITY_TYPE];
  wire        set_d  = t_chk & (tx_backplane_data != t_exp_d);
  wire        set_s  = t_chk & (tx_backplane_signaling != t_exp_s);
  wire        clr_d  = rd_take & (idx == `RBI_IDX_PAR) & rdata_reg[`RBI_TX_DATA_PARITY_ERROR_FLAG];
  wire        clr_s  = rd_take & (idx == `RBI_IDX_PAR) & rdata_reg[`RBI_TX_SIG_PARITY_ERROR_FLAG];

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tdacc_reg    <= 1'b0;
      tsacc_reg    <= 1'b0;
      tsd_flag_reg <= 1'b0;
      tss_flag_reg <= 1'b0;
      irq_reg      <= 1'b0;
    end else begin
      if (t_chk) begin
        tdacc_reg <= ext & tx_backplane_data;
        tsacc_reg <= ext & tx_backplane_signaling;
      end else if (tx_bit_valid && (!tx_fbit || ext)) begin
        tdacc_reg <= tdacc_reg ^ tx_backplane_data;
        tsacc_reg <= tsacc_reg ^ tx_backplane_signaling;
      end
      tsd_flag_reg <= set_d | (tsd_flag_reg & ~clr_d);
      tss_flag_reg <= set_s | (tss_flag_reg & ~clr_s);
      irq_reg <= par_reg[`RBI_TX_PARITY_IRQ_ENABLE] & ~frac & (tsd_flag_reg | tss_flag_reg);
    end
  end

  assign irq = irq_reg;

  // ----------------------------------------------------------------
  // Avalon-MM slave
  // ----------------------------------------------------------------
  // Reads take one wait cycle so the clear-on-read only drops bits that were returned.
  always @* begin
    if (idx == `RBI_IDX_LINE) begin
      rd_mux = line_reg;
    end else if (idx == `RBI_IDX_OPT) begin
      rd_mux = opt_reg;
    end else if (idx == `RBI_IDX_PAR) begin
      rd_mux = {par_reg[7:6], tsd_flag_reg, tss_flag_reg, par_reg[3:0]};
    end else if (idx == `RBI_IDX_CFG) begin
      rd_mux = cfg_reg;
    end else begin
      rd_mux = 8'h00;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line_reg   <= `RBI_LINE_RST;
      opt_reg    <= `RBI_OPT_RST;
      par_reg    <= `RBI_PAR_RST;
      cfg_reg    <= `RBI_CFG_RST;
      rd_ack_reg <= 1'b0;
      rdata_reg  <= 8'h00;
    end else begin
      rd_ack_reg <= avs_read & ~rd_ack_reg;
      if (avs_read && !rd_ack_reg) begin
        rdata_reg <= rd_mux;
      end
      if (wr_ok) begin
        if (idx == `RBI_IDX_LINE) begin
          line_reg <= avs_writedata[7:0] & `RBI_LINE_WMASK;
        end else if (idx == `RBI_IDX_OPT) begin
          opt_reg <= avs_writedata[7:0];
        end else if (idx == `RBI_IDX_PAR) begin
          par_reg <= avs_writedata[7:0] & `RBI_PAR_WMASK;
        end else if (idx == `RBI_IDX_CFG) begin
          cfg_reg <= avs_writedata[7:0];
        end
      end
    end
  end

  assign avs_readdata    = {24'h000000, rdata_reg};
  assign avs_waitrequest = avs_read & ~rd_ack_reg;

  assign frame_search_disable = line_reg[`RBI_UNF];
  assign sig_buffer_freeze    = line_reg[`RBI_UNF];
  assign force_out_of_frame   = line_reg[`RBI_UNF];

endmodule

// File: rbi_rx_backplane_tb.sv
// Self-checking bench of the receive backplane block.
`timescale 1ns/1ps
`include "rbi_defines.vh"
module rbi_rx_backplane_tb;
  logic        clk = 1'b0, rst_n = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0, rnd = 32'h0, pick = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic        lclk = 1'b0, ldat = 1'b0, lfb = 1'b0, lsf = 1'b0;
  logic        tx_v = 1'b0, tx_f = 1'b0, tx_d = 1'b0, tx_s = 1'b0, pd = 1'b0, ps = 1'b0;
  logic        oc_prev = 1'b0, fp_prev = 1'b0;
  wire  [31:0] rdata;
  wire  [4:0]  ch_idx;
  wire         wreq, bp_clk, bp_fs, rxd, rxd_oe, rck, rck_oe, rfp, irq, fsd, sbf, foof;
  wire  [1:0]  mxd, mxd_oe, mxs, mxs_oe, mxf, mxf_oe;
  wire         ch_sel = (ch_idx == 5'h05);
  integer      seed = 32'hc9a7e332;
  int          err_total = 0, checks_done = 0, lc = 0, bit_n = 0, fr_n = 0, oc_cnt = 0, skip = 0;
  logic [31:0] rd_q[$];
  int          cnt_q[$];
  logic [7:0]  rst_tab [4] = '{`RBI_LINE_RST, `RBI_OPT_RST, `RBI_PAR_RST, `RBI_CFG_RST};
  logic [7:0]  fp_opt [4] = '{8'h40, 8'h42, 8'h44, 8'h00};
  int          fp_exp [4] = '{193, 386, 2316, 8};

  always #2.5 clk = ~clk;

  rbi_rx_backplane u_dut (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(rdata), .avs_waitrequest(wreq), .line_rx_clock(lclk), .line_rx_data(ldat),
    .line_fbit(lfb), .line_sf_first(lsf), .esf_format(1'b0), .rx_channel_index(ch_idx),
    .channel_select_a(ch_sel), .slot_data_subst(rnd[16]), .slot_sig_subst(rnd[17]),
    .payload_control_enable(rnd[18]), .data_cond_byte(rnd[7:0]), .sig_cond_nibble(rnd[11:8]),
    .rx_sig_abcd(rnd[15:12]), .backplane_rx_clock(bp_clk), .backplane_rx_frame_input(bp_fs),
    .rx_backplane_data(rxd), .rx_backplane_data_oe(rxd_oe), .rx_output_clock(rck),
    .rx_output_clock_oe(rck_oe), .rx_frame_pulse(rfp), .mux_rx_data(mxd), .mux_rx_data_oe(mxd_oe),
    .mux_rx_signaling(mxs), .mux_rx_signaling_oe(mxs_oe), .mux_rx_frame_pulse(mxf),
    .mux_rx_frame_pulse_oe(mxf_oe), .tx_bit_valid(tx_v), .tx_fbit(tx_f), .tx_sf_first(tx_f),
    .tx_backplane_data(tx_d), .tx_backplane_signaling(tx_s), .irq(irq),
    .frame_search_disable(fsd), .sig_buffer_freeze(sbf), .force_out_of_frame(foof));
  rbi_backplane_model u_bp (.bp_clk(bp_clk), .bp_fs(bp_fs), .rx_data(rxd), .rx_data_oe(rxd_oe));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic r, input logic [5:0] i, input logic [7:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= {i, 2'h0};
    avs_read <= r;
    avs_write <= !r;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    @(posedge clk);
    while (wreq !== 1'b0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (wreq !== 1'b0) err_total++;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] i, input logic [7:0] e);
    rd_q.push_back({24'h0, e});
    bus(1'b1, i, 8'h00, 4'hf);
  endtask
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    bus(1'b0, i, d, 4'hf);
  endtask
  task automatic tx_bit(input logic f, input logic d, input logic s);
    @(posedge clk);
    tx_v <= 1'b1;
    tx_f <= f;
    tx_d <= d;
    tx_s <= s;
    @(posedge clk);
    tx_v <= 1'b0;
  endtask
  task automatic tx_rand();
    for (int k = 0; k < 24; k++) begin
      pick = $random(seed);
      pd ^= pick[0];
      ps ^= pick[1];
      tx_bit(1'b0, pick[0], pick[1]);
    end
  endtask
  task automatic stop_test();
    $display("checks_done %0d err_total %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Line source and monitors
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    lc <= (lc == 5) ? 0 : lc + 1;
    if (lc == 0) begin
      lclk <= 1'b1;
      ldat <= $random(seed);
      rnd <= $random(seed);
      lfb <= (bit_n == 0);
      lsf <= (bit_n == 0) && (fr_n == 0);
      bit_n <= (bit_n == 192) ? 0 : bit_n + 1;
      if (bit_n == 192) fr_n <= (fr_n == 11) ? 0 : fr_n + 1;
    end
    if (lc == 3) lclk <= 1'b0;
  end
  always @(posedge clk) begin
    if (rst_n && avs_read && wreq === 1'b0 && rd_q.size() > 0) begin
      cmp("readdata", rd_q.pop_front(), rdata);
    end
  end
  // Clock edges are counted between frame pulse rises; an edge on the rise opens the next span.
  always @(posedge clk) begin
    oc_prev <= rck;
    fp_prev <= rfp;
    if (rck === 1'b1 && !oc_prev) oc_cnt <= oc_cnt + 1;
    if (rfp === 1'b1 && !fp_prev) begin
      oc_cnt <= (rck === 1'b1 && !oc_prev) ? 1 : 0;
      if (skip > 0) skip <= skip - 1;
      else if (cnt_q.size() > 0) cmp("clock edges per pulse", cnt_q.pop_front(), oc_cnt);
    end
  end
  initial begin
    #600000;
    err_total++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    int n;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 4; i++) rd(i[5:0], rst_tab[i]);
    pick = $random(seed);
    wr(6'h09, pick[7:0]);
    rd(6'h09, 8'h00);
    bus(1'b0, 6'h03, pick[7:0], 4'he);
    rd(6'h03, 8'h00);
    wr(6'h03, pick[7:0]);
    rd(6'h03, pick[7:0]);
    wr(6'h01, pick[15:8]);
    rd(6'h01, pick[15:8]);
    wr(6'h01, 8'hc0);
    for (int u = 1; u >= 0; u--) begin
      wr(6'h00, {1'b0, u[0], 6'h00});
      @(negedge clk);
      cmp("unframed outputs", {3{u[0]}}, {fsd, sbf, foof});
    end
    for (int t = 0; t < 2; t++) begin
      wr(6'h03, {2'h0, t[1:0], 4'h0});
      @(negedge clk);
      cmp("data enable", t, rxd_oe);
    end
    tx_bit(1'b1, 1'b0, 1'b0);
    pd = 1'b0;
    ps = 1'b0;
    tx_rand();
    for (int t = 0; t < 2; t++) begin
      wr(6'h02, {t[0], 7'h40});
      tx_bit(1'b1, pd, ~ps);
      pd = 1'b0;
      ps = 1'b0;
      repeat (4) @(posedge clk);
      @(negedge clk);
      cmp("irq", 1, irq);
      rd(6'h02, {t[0], 1'b1, t[0], ~t[0], 4'h0});
      rd(6'h02, {t[0], 7'h40});
      tx_rand();
    end
    wr(6'h02, 8'h00);
    wr(6'h01, 8'hc8);
    for (int k = 0; k < 4; k++) begin
      wr(6'h03, {k[0], 7'h10});
      wr(6'h03, {k[0], k[1], 6'h10});
      @(negedge clk);
      n = 0;
      while (mxd_oe === 2'h0 && n < 200) begin
        @(negedge clk);
        n++;
      end
      cmp("mux data enable", k[1] ? {k[0], ~k[0]} : 2'h0, mxd_oe);
    end
    wr(6'h03, 8'h10);
    for (int i = 0; i < 4; i++) begin
      wr(6'h01, fp_opt[i]);
      skip = 2;
      cnt_q.push_back(fp_exp[i]);
      n = 0;
      while (cnt_q.size() > 0 && n < 50000) begin
        @(posedge clk);
        n++;
      end
      if (cnt_q.size() > 0) err_total++;
      cnt_q.delete();
    end
    stop_test();
  end
endmodule

bind rbi_rx_backplane rbi_checker u_chk (
  .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .rx_backplane_data_oe(rx_backplane_data_oe), .mux_rx_data_oe(mux_rx_data_oe),
  .mux_rx_signaling_oe(mux_rx_signaling_oe), .irq(irq),
  .frame_search_disable(frame_search_disable), .sig_buffer_freeze(sig_buffer_freeze),
  .force_out_of_frame(force_out_of_frame));
